// ### src/fic_pkg.sv
// Overview of operation
// R1: cache only processor instruction fetches
// R2: direct mapped, 128 bytes of data
// R3: hits answered from cache RAM, no flash
// R4: miss makes one flash fetch, slow flash
// R5: fill on cpu miss, never hub reads
// R6: hub reaches registers, cache RAM, flash
// R7: disable bit 0 bypasses the cache
// R8: log ecc status of every fill
// R9: uncorrectable fill not written, line invalidated
// R10: corrected address logged with valid flag
// R11: correction interrupt when enable bit set
// R12: failed correction address in failure register
// R13: check every flash read, latest data
// R14: flush bit 2 invalidates all in one cycle
// R15: hit count high half, misses low half
// R16: flash sleeps after threshold consecutive hits
// R17: threshold zero sleeps flash at once
// R18: wake-up invalidates lines, keeps registers
// R19: reset invalidates, fills from first fetch
// R20: fills only from flash
// R21: software invalidates after changing flash
// R22: counters wrap, no overflow flag
package fic_pkg;
  // ==========================================================
  // geometry
  localparam int unsigned CAPACITY_BYTES = 128;
  localparam int unsigned LINE_BYTES     = 4;
  localparam int unsigned LINES          = CAPACITY_BYTES / LINE_BYTES;
  localparam int unsigned INDEX_W        = $clog2(LINES);
  localparam int unsigned OFS_W          = $clog2(LINE_BYTES);
  localparam int unsigned TAG_W          = 32 - INDEX_W - OFS_W;
  localparam int unsigned ECC_ADDR_W     = 29;
  localparam int unsigned FLASH_MAX_WAIT = 4;
  // ==========================================================
  // hub spoke map
  localparam logic [15:0] OFS_CONTROL    = 16'h0000;
  localparam logic [15:0] OFS_CORR_LOG   = 16'h0004;
  localparam logic [15:0] OFS_ECC_FAIL   = 16'h0008;
  localparam logic [15:0] OFS_COUNTERS   = 16'h000c;
  localparam logic [15:0] RAM_BASE       = 16'h0100;
  localparam logic [15:0] FLASH_WIN_BASE = 16'h8000;
  // ==========================================================
  // fields
  localparam int unsigned CTL_DISABLE_BIT = 0;
  localparam int unsigned CTL_FLUSH_BIT   = 2;
  localparam int unsigned CTL_THR_LSB     = 8;
  localparam int unsigned THR_W           = 8;
  localparam int unsigned LOG_VALID_BIT   = 29;
  localparam int unsigned CORR_IRQ_EN_BIT = 30;
  localparam logic [7:0]  THR_RESET       = 8'h10;
  typedef enum logic [1:0] {FIC_IDLE, FIC_FILL, FIC_HUB_FLASH} fic_state_t;
endpackage

// ### src/fic_cache.sv
`timescale 1ns/10ps
module fic_cache (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        fetch_req,
  input  wire logic [31:0] fetch_addr,
  output logic             fetch_ready,
  output logic [31:0]      fetch_data,
  output logic             flash_req,
  output logic [31:0]      flash_addr,
  input  wire logic        flash_valid,
  input  wire logic [31:0] flash_rdata,
  input  wire logic        flash_ecc_corrected,
  input  wire logic        flash_ecc_failed,
  output logic             flash_sleep,
  input  wire logic        wake_event,
  input  wire logic        hub_sel,
  input  wire logic        hub_write,
  input  wire logic [15:0] hub_addr,
  input  wire logic [31:0] hub_wdata,
  output logic             hub_ready,
  output logic [31:0]      hub_rdata,
  output logic             correction_irq
);
  localparam int unsigned IW = fic_pkg::INDEX_W;
  localparam int unsigned OW = fic_pkg::OFS_W;
  localparam int unsigned TW = fic_pkg::TAG_W;

  // ==========================================================
  // storage and registers
  logic [31:0]              cache_ram [fic_pkg::LINES];
  logic [TW-1:0]            tag_ram   [fic_pkg::LINES];
  logic [fic_pkg::LINES-1:0] line_valid;
  fic_pkg::fic_state_t      state;
  logic                     cache_disable;
  logic [fic_pkg::THR_W-1:0] flash_sleep_hit_threshold;
  logic                     flush_pending;
  logic [fic_pkg::ECC_ADDR_W-1:0] corr_addr;
  logic                     corr_valid;
  logic                     correction_irq_enable;
  logic [fic_pkg::ECC_ADDR_W-1:0] fail_addr;
  logic                     fail_valid;
  logic [15:0]              hit_count;
  logic [15:0]              miss_count;
  logic [15:0]              seq_hits;
  logic [31:0]              req_addr;
  logic                     req_alloc;

  wire logic [IW-1:0] fetch_index = fetch_addr[OW +: IW];
  wire logic [TW-1:0] fetch_tag   = fetch_addr[31 -: TW];
  wire logic [IW-1:0] req_index   = req_addr[OW +: IW];
  wire logic [IW-1:0] hub_index   = hub_addr[OW +: IW];

  wire logic fetch_take = (state == fic_pkg::FIC_IDLE) && fetch_req && !fetch_ready;
  wire logic lookup_hit = line_valid[fetch_index] && (tag_ram[fetch_index] == fetch_tag);  // [R2]
  wire logic hit_now    = fetch_take && !cache_disable && lookup_hit;              // [R3]
  wire logic miss_now   = fetch_take && !hit_now;
  wire logic hub_flash  = hub_sel && !hub_write && !hub_ready && (hub_addr >= fic_pkg::FLASH_WIN_BASE);
  wire logic hub_take   = hub_sel && !hub_ready && !hub_flash;
  wire logic hub_fl_go  = hub_flash && (state == fic_pkg::FIC_IDLE) && !fetch_take;
  wire logic fill_done  = (state != fic_pkg::FIC_IDLE) && flash_valid;
  wire logic wr_ctl     = hub_take && hub_write && (hub_addr == fic_pkg::OFS_CONTROL);
  wire logic wr_corr    = hub_take && hub_write && (hub_addr == fic_pkg::OFS_CORR_LOG);
  wire logic wr_count   = hub_take && hub_write && (hub_addr == fic_pkg::OFS_COUNTERS);
  wire logic in_ram     = (hub_addr >= fic_pkg::RAM_BASE)
                          && (hub_addr < fic_pkg::RAM_BASE + 16'(fic_pkg::CAPACITY_BYTES));
  wire logic wr_ram     = hub_take && hub_write && in_ram;
  wire logic do_alloc   = fill_done && (state == fic_pkg::FIC_FILL) && req_alloc && !flash_ecc_failed;
  wire logic invalidate_all = flush_pending || wake_event;

  // ==========================================================
  // request sequencer: one flash access at a time, cpu first
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state     <= fic_pkg::FIC_IDLE;
      flash_req <= 1'b0;
      flash_addr <= 32'h0000_0000;
      req_addr  <= 32'h0000_0000;
      req_alloc <= 1'b0;
    end else begin
      case (state)
        fic_pkg::FIC_IDLE: begin
          if (miss_now) begin
            state      <= fic_pkg::FIC_FILL;                  // [R4]
            flash_req  <= 1'b1;
            flash_addr <= fetch_addr;                          // [R20]
            req_addr   <= fetch_addr;
            req_alloc  <= !cache_disable;                     // [R7]
          end else if (hub_fl_go) begin
            state      <= fic_pkg::FIC_HUB_FLASH;
            flash_req  <= 1'b1;
            flash_addr <= {16'h0000, hub_addr - fic_pkg::FLASH_WIN_BASE};
            req_alloc  <= 1'b0;                               // [R5]
          end
        end
        fic_pkg::FIC_FILL, fic_pkg::FIC_HUB_FLASH: begin
          // single-cycle request pulse, then wait for the flash answer
          flash_req <= 1'b0;                                   // [R4]
          if (flash_valid) begin
            state <= fic_pkg::FIC_IDLE;
          end
        end
        default: state <= fic_pkg::FIC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // cpu answer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fetch_ready <= 1'b0;
      fetch_data  <= 32'h0000_0000;
    end else begin
      fetch_ready <= hit_now || (fill_done && state == fic_pkg::FIC_FILL);
      if (hit_now) begin
        fetch_data <= cache_ram[fetch_index];                 // [R3]
      end else if (fill_done && state == fic_pkg::FIC_FILL) begin
        fetch_data <= flash_rdata;                            // [R1]
      end
    end
  end

  // ==========================================================
  // line state: flush, wake and reset clear every line
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      line_valid <= '0;                                        // [R19]
    end else if (invalidate_all) begin
      line_valid <= '0;                                        // [R14] [R18]
    end else if (fill_done && state == fic_pkg::FIC_FILL && req_alloc) begin
      line_valid[req_index] <= !flash_ecc_failed;             // [R9]
    end
  end

  // tags and data carry no reset; they mean nothing while invalid
  always_ff @(posedge clock) begin
    if (do_alloc) begin
      cache_ram[req_index] <= flash_rdata;                    // [R5]
      tag_ram[req_index]   <= req_addr[31 -: TW];
    end
    // a hub write in a fill cycle must not be lost; same word: hub wins
    if (wr_ram) begin
      cache_ram[hub_index] <= hub_wdata;                      // [R6]
    end
  end

  // ==========================================================
  // control register; flush self-clears after acting
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cache_disable             <= 1'b0;
      flash_sleep_hit_threshold <= fic_pkg::THR_RESET;
      flush_pending             <= 1'b0;
    end else begin
      flush_pending <= wr_ctl && hub_wdata[fic_pkg::CTL_FLUSH_BIT];   // [R14]
      if (wr_ctl) begin
        cache_disable             <= hub_wdata[fic_pkg::CTL_DISABLE_BIT];  // [R7]
        flash_sleep_hit_threshold <= hub_wdata[fic_pkg::CTL_THR_LSB +: fic_pkg::THR_W];
      end
    end
  end

  // ==========================================================
  // ecc logs: every flash answer is checked, set beats software clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      corr_addr             <= '0;
      corr_valid            <= 1'b0;
      correction_irq_enable <= 1'b0;
      fail_addr             <= '0;
      fail_valid            <= 1'b0;
      correction_irq        <= 1'b0;
    end else begin
      if (wr_corr) begin
        correction_irq_enable <= hub_wdata[fic_pkg::CORR_IRQ_EN_BIT];
      end
      if (fill_done && flash_ecc_corrected) begin
        corr_addr  <= flash_addr[fic_pkg::ECC_ADDR_W-1:0];    // [R8] [R10] [R13]
        corr_valid <= 1'b1;
      end else if (wr_corr && hub_wdata[fic_pkg::LOG_VALID_BIT]) begin
        corr_valid <= 1'b0;
      end
      if (fill_done && flash_ecc_failed) begin
        fail_addr  <= flash_addr[fic_pkg::ECC_ADDR_W-1:0];    // [R12] [R13]
        fail_valid <= 1'b1;
      end
      correction_irq <= corr_valid && correction_irq_enable;   // [R11]
    end
  end

  // ==========================================================
  // performance counters and flash sleep
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hit_count  <= 16'h0000;
      miss_count <= 16'h0000;
    end else if (wr_count) begin
      hit_count  <= 16'h0000;                                  // [R15]
      miss_count <= 16'h0000;
    end else begin
      hit_count  <= hit_count + 16'(hit_now);                 // [R22]
      miss_count <= miss_count + 16'(miss_now && !cache_disable);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      seq_hits    <= 16'h0000;
      flash_sleep <= 1'b0;
    end else begin
      if (miss_now || invalidate_all) begin
        seq_hits <= 16'h0000;
      end else if (hit_now && seq_hits != 16'hffff) begin
        seq_hits <= seq_hits + 16'h0001;
      end
      // a pending miss or hub read always wakes the flash in the cycle its request goes out
      flash_sleep <= !miss_now && !hub_fl_go && (state == fic_pkg::FIC_IDLE)
                     && ((flash_sleep_hit_threshold == '0)                             // [R17]
                         || (seq_hits >= 16'(flash_sleep_hit_threshold)));             // [R16]
    end
  end

  // ==========================================================
  // hub spoke answer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hub_ready <= 1'b0;
      hub_rdata <= 32'h0000_0000;
    end else begin
      hub_ready <= hub_take || (fill_done && state == fic_pkg::FIC_HUB_FLASH);
      if (fill_done && state == fic_pkg::FIC_HUB_FLASH) begin
        hub_rdata <= flash_rdata;                              // [R6]
      end else if (hub_take && !hub_write) begin
        if (in_ram) begin
          hub_rdata <= cache_ram[hub_index];                   // [R6]
        end else begin
          case (hub_addr)
            fic_pkg::OFS_CONTROL:  hub_rdata <= {16'h0000, flash_sleep_hit_threshold, 8'h00}
                                                | 32'(cache_disable);
            fic_pkg::OFS_CORR_LOG: hub_rdata <= {1'b0, correction_irq_enable, corr_valid, corr_addr};
            fic_pkg::OFS_ECC_FAIL: hub_rdata <= {2'b00, fail_valid, fail_addr};
            fic_pkg::OFS_COUNTERS: hub_rdata <= {hit_count, miss_count};
            default:               hub_rdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end
endmodule

// ### bench/fic_flash_model.sv
`timescale 1ns/10ps
module fic_flash_model (
  input  wire logic        clock,
  input  wire logic        flash_req,
  input  wire logic [31:0] flash_addr,
  input  wire logic [2:0]  lat,
  input  wire logic        corr,
  input  wire logic        fail,
  output logic             flash_valid,
  output logic [31:0]      flash_rdata,
  output logic             flash_ecc_corrected,
  output logic             flash_ecc_failed
);
  // ==========================================
  // flash array, one read outstanding
  int unsigned cnt = 0;
  initial flash_rdata = 32'h0;
  always @(posedge clock) begin
    flash_valid <= 1'b0;
    flash_ecc_corrected <= 1'b0;
    flash_ecc_failed <= 1'b0;
    // idle bus toggles so stale data never looks valid
    flash_rdata <= ~flash_rdata;
    if (cnt == 1) begin
      flash_valid <= 1'b1;
      // contents fixed per address, so software never owes a flush
      flash_rdata <= {flash_addr[15:0], ~flash_addr[15:0]};
      flash_ecc_corrected <= corr;
      flash_ecc_failed <= fail;
    end
    if (flash_req) cnt <= lat;
    else if (cnt != 0) cnt <= cnt - 1;
  end
endmodule

// ### bench/fic_cache_assertions.sv
`timescale 1ns/10ps
module fic_cache_assertions (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        fetch_req,
  input wire logic        fetch_ready,
  input wire logic [31:0] fetch_data,
  input wire logic        flash_req,
  input wire logic [31:0] flash_addr,
  input wire logic        flash_valid,
  input wire logic        flash_sleep,
  input wire logic        hub_sel,
  input wire logic        hub_write,
  input wire logic [15:0] hub_addr,
  input wire logic        hub_ready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // flash busy tracker
  logic busy;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) busy <= 1'b0;
    else if (flash_req) busy <= 1'b1;
    else if (flash_valid) busy <= 1'b0;
  end
  // hub traffic excluded: a hub flash read may hold the sequencer
  sequence s_take;
    fetch_req && !fetch_ready && !busy && !flash_req && !hub_sel;
  endsequence
  sequence s_ans;
    fetch_ready || hub_ready;
  endsequence
  a_fetch_answer: assert property (s_take |=> fetch_ready || flash_req)
    else $error("fetch not answered");
  a_one_req: assert property (flash_req |=> !flash_req [*3])
    else $error("second flash request");
  a_fill_answer: assert property (flash_valid |=> s_ans)
    else $error("fill not returned");
  a_fetch_pulse: assert property (fetch_ready |=> !fetch_ready)
    else $error("fetch ready too long");
  a_hub_ack: assert property (hub_sel && !hub_ready && (hub_write || hub_addr < 16'h8000) |=> hub_ready)
    else $error("hub not acknowledged");
  a_hub_pulse: assert property (hub_ready |=> !hub_ready)
    else $error("hub ready too long");
  a_data_hold: assert property (!fetch_ready |-> $stable(fetch_data))
    else $error("fetch data moved");
  a_addr_hold: assert property (!flash_req |-> $stable(flash_addr))
    else $error("flash address moved");
  a_sleep_miss: assert property (flash_req && fetch_req |-> !flash_sleep)
    else $error("flash asleep on miss");
endmodule
bind fic_cache fic_cache_assertions u_chk (.clock, .reset_n, .fetch_req, .fetch_ready, .fetch_data, .flash_req,
  .flash_addr, .flash_valid, .flash_sleep, .hub_sel, .hub_write, .hub_addr, .hub_ready);

// ### bench/fic_cache_tb_top.sv
`timescale 1ns/10ps
module fic_cache_tb_top;
  logic        clock, reset_n, fetch_req, flash_valid, hub_sel, hub_write, wake_event, corr, fail;
  logic        fetch_ready, flash_req, flash_sleep, hub_ready, correction_irq;
  logic        flash_ecc_corrected, flash_ecc_failed;
  logic [31:0] fetch_addr, hub_wdata, flash_rdata, fetch_data, hub_rdata, flash_addr, b;
  logic [15:0] hub_addr;
  logic [2:0]  lat;
  logic [32:0] exp_q[$];
  int          err_count = 0, num_checks = 0, nreq = 0, n, i;
  fic_cache dut (.clock, .reset_n, .fetch_req, .fetch_addr, .fetch_ready, .fetch_data, .flash_req, .flash_addr,
    .flash_valid, .flash_rdata, .flash_ecc_corrected, .flash_ecc_failed, .flash_sleep, .wake_event, .hub_sel,
    .hub_write, .hub_addr, .hub_wdata, .hub_ready, .hub_rdata, .correction_irq);
  fic_flash_model u_flash (.clock, .flash_req, .flash_addr, .lat, .corr, .fail, .flash_valid, .flash_rdata,
    .flash_ecc_corrected, .flash_ecc_failed);
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  function automatic logic [31:0] fd(logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic close_out;
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================
  // one transfer on the fetch port or the hub spoke
  task automatic xfer(bit cpu, bit w, logic [31:0] a, logic [31:0] d, logic [32:0] e);
    int k;
    @(negedge clock);
    exp_q.push_back(e);
    fetch_addr = a;
    hub_addr = a[15:0];
    hub_write = w;
    hub_wdata = d;
    fetch_req = cpu;
    hub_sel = !cpu;
    for (k = 0; k < 30 && fetch_ready !== 1'b1 && hub_ready !== 1'b1; k++) @(negedge clock);
    if (k == 30) begin
      err_count++;
      close_out();
    end
    // hold past the edge that samples ready
    @(negedge clock);
    fetch_req = 0;
    hub_sel = 0;
  endtask
  // ==========================================
  // monitor: answers against the oldest note
  always @(negedge clock) begin
    if (flash_req === 1'b1) nreq++;
    if (fetch_ready === 1'b1 || hub_ready === 1'b1) begin
      logic [32:0] e;
      e = exp_q.size() ? exp_q.pop_front() : {1'b1, 32'hx};
      if (e[32]) chk("answer", fetch_ready === 1'b1 ? fetch_data : hub_rdata, e[31:0]);
    end
  end
  initial begin
    {fetch_req, hub_sel, hub_write, wake_event, corr, fail} = 6'h0;
    fetch_addr = 0;
    hub_addr = 0;
    hub_wdata = 0;
    lat = 1;
    reset_n = 0;
    void'($urandom(32'he99a));
    b = 32'h00008000 | ($urandom & 32'h00007f00); // kept clear of the fixed test lines
    repeat (6) @(negedge clock);
    reset_n = 1;
    xfer(0, 0, 16'h0000, 0, {1'b1, 32'h00001000});
    xfer(0, 0, 16'h0004, 0, 33'h100000000);
    xfer(0, 0, 16'h0008, 0, 33'h100000000);
    xfer(0, 1, 16'h0040, 32'hffffffff, 0);
    xfer(0, 0, 16'h0040, 0, 33'h100000000);
    for (i = 0; i < 16; i++) begin
      lat = 3'd1 + 3'($urandom % 4);
      xfer(1, 0, b + 4 * (i % 8), 0, {1'b1, fd(b + 4 * (i % 8))});
    end
    chk("misses", 32'(nreq), 8);
    xfer(0, 0, 16'h000c, 0, {1'b1, 16'd8, 16'd8});
    xfer(0, 0, 16'h0104, 0, {1'b1, fd(b + 4)});
    xfer(0, 1, 16'h0108, ~b, 0);
    xfer(0, 0, 16'h0108, 0, {1'b1, ~b});
    n = nreq;
    xfer(0, 0, 16'h8040, 0, {1'b1, fd(32'h40)});
    xfer(1, 0, 32'h40, 0, {1'b1, fd(32'h40)});
    chk("no alloc", 32'(nreq - n), 2);
    xfer(0, 1, 16'h0000, 32'h00000504, 0);
    xfer(0, 0, 16'h0000, 0, {1'b1, 32'h00000500});
    n = nreq;
    repeat (2) xfer(1, 0, b, 0, {1'b1, fd(b)});
    @(negedge clock);
    wake_event = 1;
    @(negedge clock);
    wake_event = 0;
    xfer(1, 0, b, 0, {1'b1, fd(b)});
    chk("refill", 32'(nreq - n), 2);
    xfer(0, 0, 16'h0000, 0, {1'b1, 32'h00000500});
    for (i = 1; i <= 5; i++) begin
      xfer(1, 0, b, 0, {1'b1, fd(b)});
      chk("sleep", {31'h0, flash_sleep}, {31'h0, i == 5});
    end
    xfer(1, 0, 32'h80, 0, {1'b1, fd(32'h80)});
    chk("sleep", {31'h0, flash_sleep}, 0);
    xfer(0, 1, 16'h0000, 32'h0, 0);
    repeat (2) @(negedge clock);
    chk("sleep", {31'h0, flash_sleep}, 1);
    xfer(0, 1, 16'h000c, 32'h0, 0);
    xfer(0, 1, 16'h0000, 32'h00001001, 0);
    n = nreq;
    repeat (2) xfer(1, 0, b, 0, {1'b1, fd(b)});
    chk("bypass", 32'(nreq - n), 2);
    xfer(0, 0, 16'h000c, 0, 33'h100000000);
    xfer(0, 1, 16'h0000, 32'h00001000, 0);
    corr = 1;
    xfer(1, 0, 32'h200, 0, {1'b1, fd(32'h200)});
    corr = 0;
    xfer(0, 0, 16'h0004, 0, {1'b1, 32'h20000200});
    chk("irq", {31'h0, correction_irq}, 0);
    xfer(0, 1, 16'h0004, 32'h60000000, 0);
    corr = 1;
    xfer(1, 0, 32'h204, 0, {1'b1, fd(32'h204)});
    corr = 0;
    chk("irq", {31'h0, correction_irq}, 1);
    fail = 1;
    xfer(1, 0, 32'h300, 0, {1'b1, fd(32'h300)});
    fail = 0;
    xfer(0, 0, 16'h0008, 0, {1'b1, 32'h20000300});
    n = nreq;
    xfer(1, 0, 32'h300, 0, {1'b1, fd(32'h300)});
    chk("bad line", 32'(nreq - n), 1);
    close_out();
  end
endmodule
